// ===== light_comm_monitor.sv
`timescale 1ns/1ps
module light_comm_monitor (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire light_comm_pkg::net_ev_t net_ev_i,
    input wire light_comm_pkg::state_t state_o,
    input wire light_comm_pkg::key_t search_key_o,
    input wire logic net_led_o,
    input wire logic hunt_o,
    input wire logic slow_search_o,
    input wire logic join_req_o,
    input wire logic leave_req_o
);
    import light_comm_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    // ==========================================================
    // assertions
    chk_found_starts_join: assert property (
        state_o == ST_HUNT && net_ev_i.found |=> state_o == ST_JOINING && join_req_o)
        else $error("found network did not start a join");
    chk_join_result: assert property (
        state_o == ST_JOINING && net_ev_i.join_done
        |=> state_o == ($past(net_ev_i.join_ok) ? ST_JOIN_FLASH : ST_HUNT))
        else $error("join result led to wrong state");
    chk_leave_cmd: assert property (
        state_o == ST_JOINED && net_ev_i.leave |=> state_o == ST_DEPART && leave_req_o)
        else $error("leave command not obeyed");
    chk_remote_ident: assert property (
        state_o == ST_JOINED && net_ev_i.ident && !net_ev_i.leave |=> state_o == ST_IDENTIFY)
        else $error("remote identify not entered");
    chk_key_order: assert property (
        state_o == ST_HUNT && $changed(search_key_o) |-> search_key_o == KEY_INSTALL
        || search_key_o == KEY_TC_DEFAULT && $past(search_key_o) == KEY_INSTALL
        || search_key_o == KEY_DIST && $past(search_key_o) == KEY_TC_DEFAULT)
        else $error("search key out of order");
    chk_joined_quiet: assert property (
        state_o == ST_JOINED |-> !(hunt_o || slow_search_o || join_req_o))
        else $error("search activity while joined");
    chk_led_joined: assert property (
        state_o == ST_JOINED |-> net_led_o)
        else $error("status light dark while joined");
    chk_led_idle: assert property (
        state_o == ST_IDLE |-> !net_led_o)
        else $error("status light lit while unjoined");
    chk_slow_idle: assert property (
        slow_search_o |-> $past(state_o) == ST_IDLE ##1 !slow_search_o)
        else $error("slow search outside idle");
    cov_join_done: cover property (state_o == ST_JOIN_FLASH ##1 state_o == ST_JOINED);
    cov_identify: cover property (state_o == ST_JOINED ##1 state_o == ST_IDENTIFY);
    cov_report: cover property (state_o == ST_REPORT ##1 state_o == ST_JOINED);
    cov_depart: cover property (state_o == ST_DEPART ##1 state_o == ST_HUNT);
endmodule // light_comm_monitor

bind light_commissioning_fsm light_comm_monitor i_monitor (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .net_ev_i(net_ev_i), .state_o(state_o),
    .search_key_o(search_key_o), .net_led_o(net_led_o), .hunt_o(hunt_o),
    .slow_search_o(slow_search_o), .join_req_o(join_req_o), .leave_req_o(leave_req_o));

// ===== light_comm_pkg.sv
package light_comm_pkg;
    // ==========================================================
    // clock and time base
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_W = 26;
    // blink rates in millihertz, half periods derived in ms
    localparam int unsigned SLOW_BLINK_MHZ = 500;
    localparam int unsigned FAST_BLINK_MHZ = 2000;
    localparam int unsigned SLOW_HALF_MS = 1_000_000 / (2 * SLOW_BLINK_MHZ);
    localparam int unsigned FAST_HALF_MS = 1_000_000 / (2 * FAST_BLINK_MHZ);
    localparam int unsigned IDENT_LOCAL_MIN = 3;
    localparam int unsigned IDENT_LOCAL_MS = IDENT_LOCAL_MIN * 60 * MS_PER_S;
    // ==========================================================
    // counts
    localparam logic [4:0] JOIN_FLASHES = 5'h0a;
    localparam logic [4:0] DEPART_FLASHES = 5'h03;
    localparam logic [4:0] HUNT_PASSES_MAX = 5'h14;
    localparam logic [3:0] BURST_IDENT = 4'h4;
    localparam logic [3:0] BURST_REPORT_MIN = 4'h5;
    localparam logic [3:0] BURST_LEAVE = 4'ha;
    // ==========================================================
    // reset values of the pin synchronisers
    localparam logic BTN_RST = 1'b0;
    localparam logic SUPPLY_RST = 1'b1;
    // ==========================================================
    // types
    typedef enum logic [3:0] {
        ST_BOOT = 4'h0,
        ST_IDLE = 4'h1,
        ST_HUNT = 4'h2,
        ST_JOINING = 4'h3,
        ST_JOIN_FLASH = 4'h4,
        ST_JOINED = 4'h5,
        ST_IDENTIFY = 4'h6,
        ST_REPORT = 4'h7,
        ST_DEPART = 4'h8
    } state_t;

    typedef enum logic [1:0] {
        KEY_INSTALL = 2'h0,
        KEY_TC_DEFAULT = 2'h1,
        KEY_DIST = 2'h2
    } key_t;

    typedef struct packed {
        logic on;
        logic [7:0] level;
    } lamp_t;

    localparam lamp_t LAMP_OFF = '{on: 1'b0, level: 8'h00};
    localparam lamp_t LAMP_FULL = '{on: 1'b1, level: 8'hff};

    typedef struct packed {
        logic found;
        logic join_done;
        logic join_ok;
        logic leave;
        logic ident;
        logic [15:0] ident_secs;
    } net_ev_t;
endpackage

// ===== light_commissioning_fsm.sv
`timescale 1ns/1ps
module light_commissioning_fsm #(
    parameter int unsigned TICK_CYC = light_comm_pkg::CLK_HZ / light_comm_pkg::MS_PER_S,
    parameter int unsigned BURST_WINDOW_MS = 2000,
    parameter int unsigned REPORT_MS = 30000,
    parameter int unsigned KEY_SEARCH_MS = 3000,
    parameter int unsigned IDLE_SEARCH_MS = 60000
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic power_interrupt_button_i,
    input wire logic supply_ok_i,
    input wire light_comm_pkg::net_ev_t net_ev_i,
    input wire logic nv_joined_i,
    input wire light_comm_pkg::lamp_t lamp_cmd_i,
    output light_comm_pkg::lamp_t lamp_o,
    output logic net_led_o,
    output logic hunt_o,
    output light_comm_pkg::key_t search_key_o,
    output logic slow_search_o,
    output logic join_req_o,
    output logic rejoin_req_o,
    output logic leave_req_o,
    output logic nv_joined_o,
    output light_comm_pkg::state_t state_o
);
    import light_comm_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYC);

    // ==========================================================
    // power-cycle detection
    logic btn_q1, btn_q2, btn_q3;
    logic sup_q1, sup_q2, sup_q3;
    logic pc_ev, power_off;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            btn_q1 <= BTN_RST;
            btn_q2 <= BTN_RST;
            btn_q3 <= BTN_RST;
            sup_q1 <= SUPPLY_RST;
            sup_q2 <= SUPPLY_RST;
            sup_q3 <= SUPPLY_RST;
        end else begin
            btn_q1 <= power_interrupt_button_i;
            btn_q2 <= btn_q1;
            btn_q3 <= btn_q2;
            sup_q1 <= supply_ok_i;
            sup_q2 <= sup_q1;
            sup_q3 <= sup_q2;
        end
    end

    // button release or supply return both count as power coming back
    assign pc_ev = (btn_q3 & ~btn_q2) | (sup_q2 & ~sup_q3);
    assign power_off = btn_q2 | ~sup_q2;

    // ==========================================================
    // millisecond tick; every timer below counts in ms so that one
    // parameter shortens them all in simulation
    logic [TICK_W-1:0] tick_cnt;
    logic tick;

    assign tick = (tick_cnt == TICK_W'(TICK_CYC - 1));

    always_ff @(posedge core_clk_i) begin
        if (reset_i || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // ==========================================================
    // state register and timers
    state_t st, next_st;
    logic entering;
    logic [MS_W-1:0] ms_cnt, lim, ident_lim;
    logic [MS_W-1:0] blink_ms, half_lim;
    logic ms_hit, half_hit, flash_done, blink;
    logic [4:0] flash_left, pass_cnt;
    key_t key;
    logic [3:0] burst_cnt;
    logic [MS_W-1:0] win_ms;
    logic burst_ready, joined;

    assign entering = (next_st != st);
    assign ms_hit = tick && (ms_cnt >= lim - 1'b1);
    assign half_hit = tick && (blink_ms >= half_lim - 1'b1);
    assign flash_done = half_hit && (flash_left == 5'h01);
    assign burst_ready = tick && (burst_cnt != 4'h0)
        && (win_ms >= MS_W'(BURST_WINDOW_MS - 1));

    always_comb begin
        unique case (st)
            ST_IDLE: lim = MS_W'(IDLE_SEARCH_MS);
            ST_HUNT: lim = MS_W'(KEY_SEARCH_MS);
            ST_IDENTIFY: lim = ident_lim;
            ST_REPORT: lim = MS_W'(REPORT_MS);
            default: lim = MS_W'(SLOW_HALF_MS);
        endcase
        unique case (st)
            ST_JOIN_FLASH, ST_REPORT: half_lim = MS_W'(FAST_HALF_MS);
            default: half_lim = MS_W'(SLOW_HALF_MS);
        endcase
    end

    always_comb begin
        next_st = st;
        unique case (st)
            ST_BOOT: begin
                next_st = nv_joined_i ? ST_JOINED : ST_HUNT;
            end
            ST_IDLE: begin
                if (pc_ev) begin
                    next_st = ST_HUNT;
                end
            end
            ST_HUNT: begin
                if (net_ev_i.found) begin
                    next_st = ST_JOINING;
                end else if (ms_hit && !pc_ev && key == KEY_DIST
                        && pass_cnt == HUNT_PASSES_MAX - 5'h01) begin
                    next_st = ST_IDLE;
                end
            end
            ST_JOINING: begin
                if (net_ev_i.join_done) begin
                    next_st = net_ev_i.join_ok ? ST_JOIN_FLASH : ST_HUNT;
                end
            end
            ST_JOIN_FLASH: begin
                if (pc_ev || flash_done) begin
                    next_st = ST_JOINED;
                end
            end
            ST_JOINED: begin
                if (net_ev_i.leave) begin
                    next_st = ST_DEPART;
                end else if (burst_ready && burst_cnt >= BURST_IDENT) begin
                    if (burst_cnt == BURST_IDENT) begin
                        next_st = ST_IDENTIFY;
                    end else if (burst_cnt >= BURST_LEAVE) begin
                        next_st = ST_DEPART;
                    end else if (burst_cnt >= BURST_REPORT_MIN) begin
                        next_st = ST_REPORT;
                    end
                end else if (net_ev_i.ident) begin
                    next_st = ST_IDENTIFY;
                end
            end
            ST_IDENTIFY, ST_REPORT: begin
                if (pc_ev || ms_hit) begin
                    next_st = ST_JOINED;
                end
            end
            ST_DEPART: begin
                if (pc_ev || flash_done) begin
                    next_st = ST_HUNT;
                end
            end
            default: next_st = ST_BOOT;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st <= ST_BOOT;
        end else begin
            st <= next_st;
        end
    end

    // state timer; a hunt power-cycle restarts the search from KEY_INSTALL
    always_ff @(posedge core_clk_i) begin
        if (reset_i || entering || ms_hit || (st == ST_HUNT && pc_ev)) begin
            ms_cnt <= '0;
        end else if (tick) begin
            ms_cnt <= ms_cnt + 1'b1;
        end
    end

    // identify duration latched when identify is entered
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ident_lim <= MS_W'(IDENT_LOCAL_MS);
        end else if (entering && next_st == ST_IDENTIFY) begin
            if (burst_ready && burst_cnt == BURST_IDENT) begin
                ident_lim <= MS_W'(IDENT_LOCAL_MS);
            end else begin
                ident_lim <= MS_W'(net_ev_i.ident_secs * MS_PER_S);
            end
        end
    end

    // blink generator; flash_left counts half periods still to show
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            blink_ms <= '0;
            blink <= 1'b0;
            flash_left <= 5'h00;
        end else if (entering) begin
            blink_ms <= '0;
            blink <= 1'b1;
            if (next_st == ST_JOIN_FLASH) begin
                flash_left <= JOIN_FLASHES << 1;
            end else begin
                flash_left <= DEPART_FLASHES << 1;
            end
        end else if (half_hit) begin
            blink_ms <= '0;
            blink <= ~blink;
            flash_left <= flash_left - 5'h01;
        end else if (tick) begin
            blink_ms <= blink_ms + 1'b1;
        end
    end

    // key walk inside a pass, and pass count; a failed join starts over
    always_ff @(posedge core_clk_i) begin
        if (reset_i || (entering && next_st == ST_HUNT) || (st == ST_HUNT && pc_ev)) begin
            key <= KEY_INSTALL;
            pass_cnt <= 5'h00;
        end else if (st == ST_HUNT && ms_hit) begin
            if (key == KEY_DIST) begin
                key <= KEY_INSTALL;
                pass_cnt <= pass_cnt + 5'h01;
            end else begin
                key <= key_t'(key + 2'h1);
            end
        end
    end

    // burst counter; the event that ends a state is not carried over
    always_ff @(posedge core_clk_i) begin
        if (reset_i || entering || burst_ready) begin
            burst_cnt <= 4'h0;
            win_ms <= '0;
        end else if (pc_ev) begin
            win_ms <= '0;
            if (burst_cnt != BURST_LEAVE) begin
                burst_cnt <= burst_cnt + 4'h1;
            end
        end else if (tick && burst_cnt != 4'h0) begin
            win_ms <= win_ms + 1'b1;
        end
    end

    // ==========================================================
    // membership, kept outside so it survives a power loss
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            joined <= 1'b0;
        end else if (st == ST_BOOT) begin
            joined <= nv_joined_i;
        end else if (entering && next_st == ST_JOIN_FLASH) begin
            joined <= 1'b1;
        end else if (entering && next_st == ST_DEPART) begin
            joined <= 1'b0;
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            lamp_o <= LAMP_OFF;
        end else if (power_off) begin
            lamp_o <= LAMP_OFF;
        end else begin
            unique case (st)
                ST_JOINED: lamp_o <= lamp_cmd_i;
                ST_JOIN_FLASH, ST_IDENTIFY, ST_REPORT, ST_DEPART: begin
                    lamp_o <= blink ? LAMP_FULL : LAMP_OFF;
                end
                default: lamp_o <= LAMP_FULL;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hunt_o <= 1'b0;
            search_key_o <= KEY_INSTALL;
            slow_search_o <= 1'b0;
            join_req_o <= 1'b0;
            rejoin_req_o <= 1'b0;
            leave_req_o <= 1'b0;
        end else begin
            hunt_o <= (next_st == ST_HUNT);
            search_key_o <= key;
            slow_search_o <= (st == ST_IDLE) && ms_hit && !entering;
            join_req_o <= entering && next_st == ST_JOINING;
            rejoin_req_o <= (st == ST_BOOT) && nv_joined_i;
            leave_req_o <= entering && next_st == ST_DEPART;
        end
    end

    assign net_led_o = joined;
    assign nv_joined_o = joined;
    assign state_o = st;
endmodule // light_commissioning_fsm

// ===== light_commissioning_fsm_bench.sv
`timescale 1ns/1ps
module light_commissioning_fsm_bench;
    import light_comm_pkg::*;
    localparam int TICK = 4;
    localparam int WIN_MS = 20;
    localparam int REP_MS = 600;
    localparam int KEY_MS = 10;
    localparam int IDLE_MS = 40;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic button = 1'b0;
    logic supply_ok = 1'b1;
    logic nv_joined = 1'b0;
    logic open_net = 1'b0;
    logic accept = 1'b0;
    logic [3:0] lag = 4'h3;
    logic leave_cmd = 1'b0;
    logic ident_cmd = 1'b0;
    logic [15:0] ident_secs = 16'h0000;
    lamp_t lamp_cmd = LAMP_OFF;
    logic found, join_done, join_ok, net_led, hunt, slow_search, join_req, rejoin_req, leave_req;
    logic nv_out;
    lamp_t lamp_o;
    net_ev_t net_ev;
    key_t key;
    key_t k;
    state_t state;
    logic pv;
    int num_errors = 0;
    int n_tests = 0;
    int t;
    int n;
    always #4 core_clk_i = ~core_clk_i;
    assign net_ev = '{found: found, join_done: join_done, join_ok: join_ok, leave: leave_cmd,
        ident: ident_cmd, ident_secs: ident_secs};
    light_commissioning_fsm #(.TICK_CYC(TICK), .BURST_WINDOW_MS(WIN_MS), .REPORT_MS(REP_MS),
        .KEY_SEARCH_MS(KEY_MS), .IDLE_SEARCH_MS(IDLE_MS)) i_dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .power_interrupt_button_i(button),
        .supply_ok_i(supply_ok), .net_ev_i(net_ev), .nv_joined_i(nv_joined),
        .lamp_cmd_i(lamp_cmd), .lamp_o(lamp_o), .net_led_o(net_led), .hunt_o(hunt),
        .search_key_o(key), .slow_search_o(slow_search), .join_req_o(join_req),
        .rejoin_req_o(rejoin_req), .leave_req_o(leave_req), .nv_joined_o(nv_out), .state_o(state));
    radio_stack_model i_radio (.core_clk_i(core_clk_i), .hunt_i(hunt), .join_req_i(join_req),
        .open_net_i(open_net), .accept_i(accept), .lag_i(lag), .found_o(found),
        .join_done_o(join_done), .join_ok_o(join_ok));
    // ==========================================================
    // helpers
    task automatic results();
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g, input int tol);
        n_tests++;
        if ((tol == 0) ? (g !== e) : (g + tol < e || g > e + tol)) begin
            $display("Error %s expected %0d seen %0d", s, e, g);
            num_errors++;
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge core_clk_i);
    endtask
    task automatic wait_st(input state_t s, input int lim);
        t = 0;
        while (state !== s) begin
            cyc(1);
            t++;
            if (t > lim) begin
                chk("state", s, state, 0);
                results();
            end
        end
    endtask
    // one power-cycle on either pin; both pins idle outside it
    task automatic pc(input bit sup);
        supply_ok = !sup;
        button = !sup;
        cyc(4);
        supply_ok = 1'b1;
        button = 1'b0;
        cyc(6);
    endtask
    task automatic half(input int e);
        repeat (2) begin
            pv = lamp_o.on;
            t = 0;
            while (lamp_o.on === pv && t < 9000) begin
                cyc(1);
                t++;
            end
        end
        chk("half period", e, t, 3);
    endtask
    // ==========================================================
    // sequence
    initial begin
        n = $urandom(52);
        cyc(2);
        reset_i = 1'b0;
        cyc(2);
        chk("boot state", ST_HUNT, state, 0);
        k = KEY_INSTALL;
        t = 2;
        while (state !== ST_IDLE && t < 3000) begin
            cyc(1);
            t++;
            if (state === ST_HUNT && key !== k) begin
                chk("key", (k == KEY_DIST) ? KEY_INSTALL : k + 1, key, 0);
                k = key;
            end
        end
        chk("passes", 60 * KEY_MS * TICK, t, 12);
        t = 0;
        while (slow_search !== 1'b1 && t < IDLE_MS * TICK + 20) begin
            cyc(1);
            t++;
        end
        chk("slow search", 1, slow_search, 0);
        chk("plain lamp", LAMP_FULL, lamp_o, 0);
        pc(0);
        wait_st(ST_HUNT, 10);
        cyc(60);
        pc(1);
        chk("key restart", KEY_INSTALL, key, 0);
        t = 0;
        while (key === KEY_INSTALL && t < 200) begin
            cyc(1);
            t++;
        end
        chk("key time", KEY_MS * TICK - 3, t, 8);
        lag = 4'($urandom_range(15, 1));
        open_net = 1'b1;
        wait_st(ST_JOINING, 200);
        chk("join req", 1, join_req, 0);
        wait_st(ST_HUNT, 40);
        accept = 1'b1;
        wait_st(ST_JOIN_FLASH, 200);
        open_net = 1'b0;
        chk("led joining", 1, net_led, 0);
        chk("nv store", 1, nv_out, 0);
        wait_st(ST_JOINED, 21000);
        chk("join flashes", 20 * FAST_HALF_MS * TICK, t, 12);
        repeat (3) begin
            lamp_cmd = 9'($urandom);
            cyc(3);
            chk("lamp cmd", lamp_cmd, lamp_o, 0);
        end
        // a known lamp level fixes the blink phase that the timings below assume
        lamp_cmd = LAMP_FULL;
        repeat (2) pc(1'($urandom));
        cyc(WIN_MS * TICK + 20);
        chk("short burst", ST_JOINED, state, 0);
        repeat (4) pc(1'($urandom));
        wait_st(ST_IDENTIFY, WIN_MS * TICK + 40);
        chk("led identify", 1, net_led, 0);
        half(SLOW_HALF_MS * TICK);
        pc(1);
        wait_st(ST_JOINED, 4);
        repeat ($urandom_range(9, 5)) pc(1'($urandom));
        wait_st(ST_REPORT, WIN_MS * TICK + 40);
        half(FAST_HALF_MS * TICK);
        wait_st(ST_JOINED, REP_MS * TICK);
        chk("report time", (REP_MS - 2 * FAST_HALF_MS) * TICK, t, 12);
        ident_secs = 16'h0001;
        ident_cmd = 1'b1;
        cyc(1);
        ident_cmd = 1'b0;
        ident_secs = 16'($urandom);
        wait_st(ST_IDENTIFY, 2);
        wait_st(ST_JOINED, 4100);
        chk("remote ident", MS_PER_S * TICK, t, 8);
        repeat (10) pc(1'($urandom));
        wait_st(ST_DEPART, WIN_MS * TICK + 40);
        chk("leave req", 1, leave_req, 0);
        cyc(100);
        pc(0);
        wait_st(ST_HUNT, 4);
        cyc(2);
        chk("led hunt", 0, net_led, 0);
        chk("nv clear", 0, nv_out, 0);
        open_net = 1'b1;
        wait_st(ST_JOIN_FLASH, 300);
        open_net = 1'b0;
        cyc(50);
        pc(1);
        wait_st(ST_JOINED, 4);
        // second power-up with stored membership
        nv_joined = 1'b1;
        lamp_cmd = LAMP_OFF;
        reset_i = 1'b1;
        cyc(2);
        reset_i = 1'b0;
        n = 0;
        repeat (4) begin
            cyc(1);
            n += rejoin_req;
        end
        chk("rejoin", 1, n, 0);
        chk("rejoin hunt", 0, hunt, 0);
        leave_cmd = 1'b1;
        cyc(1);
        leave_cmd = 1'b0;
        wait_st(ST_DEPART, 2);
        n = 0;
        t = 0;
        pv = lamp_o.on;
        while (state === ST_DEPART && t < 30000) begin
            cyc(1);
            t++;
            n += (pv === 1'b1 && lamp_o.on === 1'b0);
            pv = lamp_o.on;
        end
        chk("depart flashes", 3, n, 0);
        chk("depart time", 6 * SLOW_HALF_MS * TICK, t, 12);
        results();
    end
endmodule // light_commissioning_fsm_bench

// ===== radio_stack_model.sv
`timescale 1ns/1ps
module radio_stack_model (
    input wire logic core_clk_i,
    input wire logic hunt_i,
    input wire logic join_req_i,
    input wire logic open_net_i,
    input wire logic accept_i,
    input wire logic [3:0] lag_i,
    output logic found_o,
    output logic join_done_o,
    output logic join_ok_o
);
    logic [3:0] scan_cnt = 4'h0;
    logic [4:0] join_cnt = 5'h00;
    initial begin
        found_o = 1'b0;
        join_done_o = 1'b0;
        join_ok_o = 1'b0;
    end
    // ==========================================================
    // beacon and join answers, changed on the falling edge
    always @(negedge core_clk_i) begin
        found_o <= 1'b0;
        scan_cnt <= (hunt_i && open_net_i) ? scan_cnt + 4'h1 : 4'h0;
        if (hunt_i && open_net_i && scan_cnt == lag_i) begin
            found_o <= 1'b1;
        end
        join_done_o <= 1'b0;
        // result line carries nothing outside the done pulse, so it toggles
        join_ok_o <= ~join_ok_o;
        if (join_req_i) begin
            join_cnt <= {1'b0, lag_i} + 5'h01;
        end else if (join_cnt != 5'h00) begin
            join_cnt <= join_cnt - 5'h01;
        end
        if (join_cnt == 5'h01) begin
            join_done_o <= 1'b1;
            join_ok_o <= accept_i;
        end
    end
endmodule // radio_stack_model
